// ### src/multichannel_hall_pattern_unit.sv
// multi-channel output pattern and hall pattern logic, AXI4-Lite slave
// assumes timer events and PWM inputs are one-cycle/level signals
// synchronous to i_clk_sys; hall pins are synchronous as well
`include "mch_cfg.svh"
module multichannel_hall_pattern_unit (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [2:0] i_hall_pins,
  input wire logic [5:0] i_pwm_timer_a,
  input wire logic [5:0] i_pwm_timer_b,
  input wire logic i_timer_a_period_match,
  input wire logic i_timer_a_one_match,
  input wire logic i_timer_a_ch1_match,
  input wire logic i_timer_a_zero_match_up,
  input wire logic i_timer_b_period_match,
  input wire logic i_timer_b_zero_match,
  output logic o_ch0_main_out,
  output logic o_ch0_compl_out,
  output logic o_ch1_main_out,
  output logic o_ch1_compl_out,
  output logic o_ch2_main_out,
  output logic o_ch2_compl_out,
  output logic o_correct_hall_irq,
  output logic o_wrong_hall_irq,
  output logic o_timer_a_shadow_transfer,
  output logic o_timer_b_shadow_transfer
);

  mch_pkg::unit_state_t q;
  mch_pkg::unit_state_t d;

  // address decode, shared by the read and write paths
  function automatic mch_pkg::reg_sel_t reg_sel(input logic [7:0] a);
    case (a)
      `OFF_CTRL: reg_sel = mch_pkg::SEL_CTRL;
      `OFF_ACT: reg_sel = mch_pkg::SEL_ACT;
      `OFF_SHD: reg_sel = mch_pkg::SEL_SHD;
      `OFF_MOD: reg_sel = mch_pkg::SEL_MOD;
      `OFF_STAT: reg_sel = mch_pkg::SEL_STAT;
      `OFF_IEN: reg_sel = mch_pkg::SEL_IEN;
      default: reg_sel = mch_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  // read image; request bits and reserved bits read as zero
  function automatic logic [15:0] reg_read(
    input mch_pkg::unit_state_t s,
    input mch_pkg::reg_sel_t sel
  );
    case (sel)
      mch_pkg::SEL_CTRL: reg_read = s.ctrl;
      mch_pkg::SEL_ACT: reg_read = {2'h0, s.current_hall_active, s.expected_hall_active, 1'b0, s.rem, s.pat};
      mch_pkg::SEL_SHD: reg_read = {2'h0, s.current_hall_shadow, s.expected_hall_shadow, 2'h0, s.pats};
      mch_pkg::SEL_MOD: reg_read = s.mod;
      mch_pkg::SEL_STAT: reg_read = {s.str, s.idle, s.wrong_hall_event_flag, s.correct_hall_event_flag, 12'h000};
      mch_pkg::SEL_IEN: reg_read = s.ien;
      default: reg_read = `REG_RESET;
    endcase
  endfunction : reg_read

  // byte-lane merge of a write into a 16-bit register image
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    merge[15:8] = strb[1] ? data[15:8] : old[15:8];
    merge[7:0] = strb[0] ? data[7:0] : old[7:0];
  endfunction : merge

  logic e_hit;
  logic [2:0] e_pins;

  hall_edge_detect u_edge (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_hall_pins(i_hall_pins),
    .o_edge(e_hit),
    .o_pins(e_pins)
  );

  mch_pkg::reg_sel_t wsel;
  mch_pkg::reg_sel_t rsel;
  logic wr_fire;
  logic [15:0] wv;
  logic [15:0] w1;
  logic [2:0] w_current_hall_shadow;
  logic [2:0] w_expected_hall_shadow;
  logic [5:0] w_pats;
  logic swh;
  logic swp;
  logic multichannel_enable;
  logic spike;
  logic che_ev;
  logic whe_ev;
  logic trig;
  logic sync_ok;
  logic pending;
  logic hw_xfer;
  logic stat_wr;
  logic [5:0] pwm;

  // write decode; bus writes go one at a time once address and data meet
  assign wr_fire = q.aw_full && q.w_full && !q.bvalid;
  assign wsel = reg_sel(q.awaddr);
  assign rsel = reg_sel(i_araddr);
  assign wv = merge(reg_read(q, wsel), q.wdata, q.wstrb);
  assign w1 = merge(`REG_RESET, q.wdata, q.wstrb);
  assign w_current_hall_shadow = wv[`F_CURRENT_HALL_ACTIVE];
  assign w_expected_hall_shadow = wv[`F_EXPECTED_HALL_ACTIVE];
  assign w_pats = wv[`F_PAT];
  assign stat_wr = wr_fire && (wsel == mch_pkg::SEL_STAT);
  assign swh = wr_fire && (wsel == mch_pkg::SEL_SHD) && wv[`B_HREQ];
  assign swp = wr_fire && (wsel == mch_pkg::SEL_SHD) && wv[`B_PREQ];
  assign multichannel_enable = q.mod[`B_MULTICHANNEL_ENABLE];

  // hall classification against the patterns active before the edge
  assign spike = e_hit && (e_pins == q.current_hall_active);
  assign che_ev = e_hit && !spike && (e_pins == q.expected_hall_active);
  assign whe_ev = e_hit && !spike && (e_pins != q.expected_hall_active);

  // trigger source selection; reserved codes request nothing
  assign trig =
    ((q.ctrl[`F_SEL] == `SEL_CORRECT) && che_ev) ||
    ((q.ctrl[`F_SEL] == `SEL_TB_PM) && i_timer_b_period_match) ||
    ((q.ctrl[`F_SEL] == `SEL_TA_OM) && i_timer_a_one_match) ||
    ((q.ctrl[`F_SEL] == `SEL_TA_C1) && i_timer_a_ch1_match) ||
    ((q.ctrl[`F_SEL] == `SEL_TA_PM) && i_timer_a_period_match);

  // synchronisation; code 11 never fires, so the request just waits
  assign sync_ok =
    (q.ctrl[`F_SYN] == `SYN_DIRECT) ||
    ((q.ctrl[`F_SYN] == `SYN_TB_ZERO) && i_timer_b_zero_match) ||
    ((q.ctrl[`F_SYN] == `SYN_TA_ZERO) && i_timer_a_zero_match_up);
  assign pending = multichannel_enable && (q.rem || trig);
  assign hw_xfer = pending && sync_ok;

  // PWM of either timer as the modulation enables select
  assign pwm = (q.mod[`F_MOD_A] & i_pwm_timer_a) |
               (q.mod[`F_MOD_B] & i_pwm_timer_b);

  // next-state logic for bus, registers, patterns and outputs
  always_comb begin
    d = q;
    if (q.awready && i_awvalid) begin
      d.aw_full = 1'b1;
      d.awaddr = i_awaddr;
    end
    if (q.wready && i_wvalid) begin
      d.w_full = 1'b1;
      d.wdata = i_wdata;
      d.wstrb = i_wstrb;
    end
    if (q.bvalid && i_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (wsel == mch_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      case (wsel)
        mch_pkg::SEL_CTRL: d.ctrl = wv & `CTRL_MASK;
        mch_pkg::SEL_MOD: d.mod = wv & `MOD_MASK;
        mch_pkg::SEL_IEN: d.ien = wv & `IEN_MASK;
        mch_pkg::SEL_SHD: begin
          d.current_hall_shadow = w_current_hall_shadow;
          d.expected_hall_shadow = w_expected_hall_shadow;
          d.pats = w_pats;
        end
        default: ;
      endcase
    end
    if (q.rvalid && i_rready) begin
      d.rvalid = 1'b0;
    end
    if (q.arready && i_arvalid) begin
      d.rvalid = 1'b1;
      d.rdata = {16'h0000, reg_read(q, rsel)};
      d.rresp = (rsel == mch_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    // one outstanding transfer per direction keeps the slave trivial
    d.awready = !d.aw_full;
    d.wready = !d.w_full;
    d.arready = !d.rvalid;

    // hall patterns: edge copy first, software request overrides it
    if (e_hit) begin
      d.current_hall_active = q.current_hall_shadow;
      d.expected_hall_active = q.expected_hall_shadow;
    end
    if (swh) begin
      d.current_hall_active = w_current_hall_shadow;
      d.expected_hall_active = w_expected_hall_shadow;
    end

    // sticky flags: a same-cycle event beats a software clear
    d.correct_hall_event_flag = (q.correct_hall_event_flag && !(stat_wr && w1[`B_CHE])) || che_ev;
    d.wrong_hall_event_flag = (q.wrong_hall_event_flag && !(stat_wr && w1[`B_WHE])) || whe_ev;
    d.idle = (q.idle && !(stat_wr && w1[`B_IDLE])) || whe_ev;
    d.str = (q.str && !(stat_wr && w1[`B_STR])) ||
            hw_xfer || (swp && multichannel_enable);
    d.irq_che = che_ev && q.ien[`B_CHE];
    d.irq_whe = whe_ev && q.ien[`B_WHE];

    // reminder survives only until the transfer, never while disabled
    d.rem = pending && !hw_xfer && !swp;

    // active pattern: hardware, then software, then idle clear
    if (hw_xfer) begin
      d.pat = q.pats;
    end
    if (swp) begin
      d.pat = w_pats;
    end
    if (d.idle) begin
      d.pat = 6'h00;
    end

    // timer shadow transfers requested while a pattern change pends
    d.ta_st = pending &&
      ((q.ctrl[`B_TA_DN] && i_timer_a_one_match) ||
       (q.ctrl[`B_TA_UP] && i_timer_a_period_match));
    d.tb_st = pending && q.ctrl[`B_TB_UP] && i_timer_b_period_match;

    // output gating, bypassed when multi-channel mode is off
    d.outs = multichannel_enable ? (pwm & q.pat) : pwm;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // every output straight from the state register
  assign o_awready = q.awready;
  assign o_wready = q.wready;
  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_arready = q.arready;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;
  assign o_ch0_main_out = q.outs[0];
  assign o_ch0_compl_out = q.outs[1];
  assign o_ch1_main_out = q.outs[2];
  assign o_ch1_compl_out = q.outs[3];
  assign o_ch2_main_out = q.outs[4];
  assign o_ch2_compl_out = q.outs[5];
  assign o_correct_hall_irq = q.irq_che;
  assign o_wrong_hall_irq = q.irq_whe;
  assign o_timer_a_shadow_transfer = q.ta_st;
  assign o_timer_b_shadow_transfer = q.tb_st;

  // checks on the pattern behaviour
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  sequence s_pend_tb_zero;
    multichannel_enable && q.rem && (q.ctrl[`F_SYN] == `SYN_TB_ZERO);
  endsequence

  sequence s_plain_wrong;
    whe_ev && !swp;
  endsequence

  chk_hall_sw_load: assert property (
    swh |=> (q.current_hall_active == $past(w_current_hall_shadow)) && (q.expected_hall_active == $past(w_expected_hall_shadow)))
    else $error("hall software request did not load active patterns");

  chk_hall_edge_cur: assert property (
    e_hit && !swh |=> q.current_hall_active == $past(q.current_hall_shadow))
    else $error("hall edge did not copy current shadow");

  chk_hall_edge_exp: assert property (
    e_hit && !swh |=> q.expected_hall_active == $past(q.expected_hall_shadow))
    else $error("hall edge did not copy expected shadow");

  chk_spike_no_flag: assert property (
    spike && !q.correct_hall_event_flag && !q.wrong_hall_event_flag && !stat_wr |=> !q.correct_hall_event_flag && !q.wrong_hall_event_flag)
    else $error("spike edge raised a hall flag");

  chk_correct_flag: assert property (
    e_hit && (e_pins != q.current_hall_active) && (e_pins == q.expected_hall_active)
      |=> q.correct_hall_event_flag && (q.irq_che == $past(q.ien[`B_CHE])))
    else $error("correct hall event not flagged");

  chk_wrong_then_idle: assert property (
    s_plain_wrong |=> q.wrong_hall_event_flag && q.idle && (q.pat == 6'h00) ##1 !q.irq_whe)
    else $error("wrong hall event did not flag and idle");

  chk_idle_holds_zero: assert property (
    q.idle |-> q.pat == 6'h00)
    else $error("active pattern not zero while idle");

  chk_rem_disabled: assert property (
    !multichannel_enable |=> !q.rem)
    else $error("reminder set while multi-channel disabled");

  chk_pattern_sw: assert property (
    swp && !d.idle |=> q.pat == $past(w_pats))
    else $error("pattern software request did not load");

  chk_sync_transfer: assert property (
    s_pend_tb_zero ##0 (i_timer_b_zero_match && !swp && !d.idle)
      |=> (q.pat == $past(q.pats)) && !q.rem && q.str)
    else $error("pending transfer missed timer_b zero match");

  chk_reserved_sync: assert property (
    (q.ctrl[`F_SYN] == 2'h3) && !swp && !d.idle |=> $stable(q.pat))
    else $error("pattern moved with reserved sync select");

  chk_gate_passive: assert property (
    multichannel_enable && !q.pat[0] |=> !o_ch0_main_out)
    else $error("zero pattern bit did not force passive output");

endmodule : multichannel_hall_pattern_unit

// ### src/mch_cfg.svh
// register offsets, field positions, reset value and codes for the
// multi-channel / hall pattern unit; definitions only
`ifndef MCH_CFG_SVH
`define MCH_CFG_SVH

// byte offsets on the 8-bit register address
`define OFF_CTRL 8'h54
`define OFF_SHD 8'h58
`define OFF_MOD 8'h5c
`define OFF_ACT 8'h64
`define OFF_STAT 8'h68
`define OFF_IEN 8'h6c
`define REG_RESET 16'h0000

// shadow and active output registers
`define B_HREQ 15
`define F_CURRENT_HALL_ACTIVE 13:11
`define F_EXPECTED_HALL_ACTIVE 10:8
`define B_PREQ 7
`define B_REM 6
`define F_PAT 5:0

// multi-channel control register
`define B_TB_UP 10
`define B_TA_DN 9
`define B_TA_UP 8
`define F_SYN 5:4
`define F_SEL 2:0
`define CTRL_MASK 16'h0737

// modulation control register
`define B_MULTICHANNEL_ENABLE 7
`define F_MOD_A 5:0
`define F_MOD_B 13:8
`define MOD_MASK 16'h3fbf

// status flags and interrupt request enables
`define B_STR 15
`define B_IDLE 14
`define B_WHE 13
`define B_CHE 12
`define IEN_MASK 16'h3000

// trigger source and synchronisation codes
`define SEL_CORRECT 3'h1
`define SEL_TB_PM 3'h2
`define SEL_TA_OM 3'h3
`define SEL_TA_C1 3'h4
`define SEL_TA_PM 3'h5
`define SYN_DIRECT 2'h0
`define SYN_TB_ZERO 2'h1
`define SYN_TA_ZERO 2'h2

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### src/mch_pkg.sv
// types shared by the multi-channel / hall pattern unit
// assumes nothing beyond a SystemVerilog compiler
package mch_pkg;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_CTRL, SEL_ACT, SEL_SHD, SEL_MOD, SEL_STAT, SEL_IEN, SEL_NONE
  } reg_sel_t;

  // hall edge detector state
  typedef struct packed {
    logic armed;
    logic [2:0] prev;
    logic hit;
    logic [2:0] pins;
  } edge_state_t;

  // whole state of the pattern unit
  typedef struct packed {
    logic awready;
    logic aw_full;
    logic [7:0] awaddr;
    logic wready;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] ctrl;
    logic [15:0] mod;
    logic [15:0] ien;
    logic [2:0] current_hall_shadow;
    logic [2:0] expected_hall_shadow;
    logic [5:0] pats;
    logic [2:0] current_hall_active;
    logic [2:0] expected_hall_active;
    logic [5:0] pat;
    logic rem;
    logic str;
    logic idle;
    logic wrong_hall_event_flag;
    logic correct_hall_event_flag;
    logic irq_che;
    logic irq_whe;
    logic ta_st;
    logic tb_st;
    logic [5:0] outs;
  } unit_state_t;

endpackage : mch_pkg

// ### src/hall_edge_detect.sv
// edge detector on the three hall sensor inputs
// assumes the pins are already synchronous to i_clk_sys
module hall_edge_detect (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [2:0] i_hall_pins,
  output logic o_edge,
  output logic [2:0] o_pins
);

  mch_pkg::edge_state_t q;
  mch_pkg::edge_state_t d;

  // first sample after reset only arms, so a nonzero level is no edge
  always_comb begin
    d = q;
    d.armed = 1'b1;
    d.prev = i_hall_pins;
    d.hit = q.armed && (i_hall_pins != q.prev);
    d.pins = i_hall_pins;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_edge = q.hit;
  assign o_pins = q.pins;

endmodule : hall_edge_detect

// ### tb/hall_stage_model.sv
// far-side model: three hall sensors and the six-input power stage
// assumes the bench commands the hall pattern between clock edges
module hall_stage_model (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [2:0] i_hall_cmd,
  input wire logic i_ch0_main,
  input wire logic i_ch0_compl,
  input wire logic i_ch1_main,
  input wire logic i_ch1_compl,
  input wire logic i_ch2_main,
  input wire logic i_ch2_compl,
  output logic [2:0] o_hall_pins,
  output logic [5:0] o_stage_gates
);
  timeunit 1ns;
  timeprecision 1ns;

  // sensors settle just after an edge; pin n carries sensor n, so a
  // pattern is never bit-reversed on its way to the unit
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hall_pins <= i_hall_cmd;
    end else begin
      o_hall_pins <= i_hall_cmd;
    end
  end

  // stage latches its gate inputs, bit 0 = channel 0 main side
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_stage_gates <= 6'h00;
    end else begin
      o_stage_gates <= {i_ch2_compl, i_ch2_main, i_ch1_compl, i_ch1_main,
                        i_ch0_compl, i_ch0_main};
    end
  end
endmodule : hall_stage_model

// ### tb/testbench.sv
// self-checking bench for the multi-channel / hall pattern unit
// assumes the unit, its package and the hall/stage model are compiled
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hf;
  logic [5:0] tm = 6'h00; // period a, one a, ch1 a, zero a, period b, zero b
  logic [2:0] hall_cmd = 3'h5;
  logic [5:0] pwm_b = 6'h00;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] hall;
  logic [5:0] gates;
  logic c0m, c0c, c1m, c1c, c2m, c2c, irq_c, irq_w, st_a, st_b;
  logic [5:0] cur;
  logic [31:0] d;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_ic = 0;
  int n_iw = 0;
  int n_sa = 0;
  int n_sb = 0;

  // 20 MHz system clock
  always #25 clk = ~clk;

  multichannel_hall_pattern_unit uut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_hall_pins(hall), .i_pwm_timer_a(6'h3f),
    .i_pwm_timer_b(pwm_b), .i_timer_a_period_match(tm[0]),
    .i_timer_a_one_match(tm[1]), .i_timer_a_ch1_match(tm[2]),
    .i_timer_a_zero_match_up(tm[3]), .i_timer_b_period_match(tm[4]),
    .i_timer_b_zero_match(tm[5]), .o_ch0_main_out(c0m),
    .o_ch0_compl_out(c0c), .o_ch1_main_out(c1m), .o_ch1_compl_out(c1c),
    .o_ch2_main_out(c2m), .o_ch2_compl_out(c2c),
    .o_correct_hall_irq(irq_c), .o_wrong_hall_irq(irq_w),
    .o_timer_a_shadow_transfer(st_a), .o_timer_b_shadow_transfer(st_b));

  hall_stage_model partner (
    .i_clk_sys(clk), .i_rstn(rstn), .i_hall_cmd(hall_cmd),
    .i_ch0_main(c0m), .i_ch0_compl(c0c), .i_ch1_main(c1m),
    .i_ch1_compl(c1c), .i_ch2_main(c2m), .i_ch2_compl(c2c),
    .o_hall_pins(hall), .o_stage_gates(gates));

  // one-cycle pulses are counted so no single edge can be missed
  always @(posedge clk) begin
    if (irq_c === 1'b1) n_ic++;
    if (irq_w === 1'b1) n_iw++;
    if (st_a === 1'b1) n_sa++;
    if (st_b === 1'b1) n_sb++;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // address and data offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] v,
                    input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, v};
    bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk($sformatf("bresp %h", a), {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk($sformatf("rdata %h", a), rdata, exp);
        chk($sformatf("rresp %h", a), {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask : rd

  task automatic pulse(input int b);
    @(posedge clk);
    tm[b] <= 1'b1;
    @(posedge clk);
    tm[b] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // sensor register, edge detector and flag update need a few cycles
  task automatic pins(input logic [2:0] p);
    @(posedge clk);
    hall_cmd <= p;
    repeat (5) @(posedge clk);
  endtask : pins

  task automatic outs_chk(input logic [5:0] e);
    repeat (3) @(posedge clk);
    chk("stage gates", {26'h0, gates}, {26'h0, e});
  endtask : outs_chk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // whole sequence needs a few hundred cycles; cut a hang well after
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("Error watchdog expected done seen hang");
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h54, 32'h0, 2'h0);
    rd(8'h58, 32'h0, 2'h0);
    rd(8'h64, 32'h0, 2'h0);
    rd(8'h70, 32'h0, 2'h2);
    wr(8'h70, 16'hffff, 2'h2);
    wr(8'h54, 16'hffff, 2'h0);
    rd(8'h54, 32'h0737, 2'h0);
    $display("test reset and control finished");
    wr(8'h54, 16'h0000, 2'h0);
    wr(8'h5c, 16'h00bf, 2'h0);
    wr(8'h58, 16'h0095, 2'h0);
    rd(8'h64, 32'h0015, 2'h0);
    rd(8'h58, 32'h0015, 2'h0);
    outs_chk(6'h15);
    wr(8'h58, 16'h002a, 2'h0);
    rd(8'h64, 32'h0015, 2'h0);
    wr(8'h5c, 16'h003f, 2'h0);
    outs_chk(6'h3f);
    wr(8'h5c, 16'h00bf, 2'h0);
    $display("test output pattern finished");
    wr(8'h58, 16'hac2a, 2'h0);
    rd(8'h64, 32'h2c15, 2'h0);
    rd(8'h58, 32'h2c2a, 2'h0);
    wr(8'h58, 16'h0b2a, 2'h0);
    rd(8'h64, 32'h2c15, 2'h0);
    $display("test hall request finished");
    wr(8'h6c, 16'h3000, 2'h0);
    wr(8'h54, 16'h0001, 2'h0);
    wr(8'h68, 16'hffff, 2'h0);
    pins(3'h4);
    rd(8'h68, 32'h9000, 2'h0);
    rd(8'h64, 32'h0b2a, 2'h0);
    chk("correct irq count", n_ic, 1);
    outs_chk(6'h2a);
    wr(8'h68, 16'hffff, 2'h0);
    pins(3'h1);
    rd(8'h68, 32'h0000, 2'h0);
    pins(3'h6);
    rd(8'h68, 32'h6000, 2'h0);
    chk("wrong irq count", n_iw, 1);
    rd(8'h64, 32'h0b00, 2'h0);
    outs_chk(6'h00);
    wr(8'h58, 16'h0bbf, 2'h0);
    rd(8'h64, 32'h0b00, 2'h0);
    wr(8'h68, 16'hffff, 2'h0);
    $display("test hall events finished");
    wr(8'h54, 16'h0115, 2'h0);
    pulse(0);
    chk("timer a transfers", n_sa, 1);
    pulse(5);
    rd(8'h64, 32'h0b3f, 2'h0);
    wr(8'h54, 16'h0412, 2'h0);
    pulse(4);
    chk("timer b transfers", n_sb, 1);
    pulse(5);
    rd(8'h64, 32'h0b3f, 2'h0);
    cur = 6'h3f;
    // sync codes 1 to 3: trigger, then timer b zero, then timer a zero
    for (int i = 1; i < 4; i++) begin
      d = 32'h0b00 | (i * 32'h11);
      wr(8'h58, d[15:0], 2'h0);
      wr(8'h54, 16'h0005 | (16'h0010 * i[15:0]), 2'h0);
      pulse(0);
      rd(8'h64, {25'h0000016, 1'b1, cur}, 2'h0);
      pulse(5);
      if (i == 1) cur = d[5:0];
      rd(8'h64, {25'h0000016, i != 1, cur}, 2'h0);
      pulse(3);
      if (i == 2) cur = d[5:0];
      rd(8'h64, {25'h0000016, i == 3, cur}, 2'h0);
    end
    // one-match trigger, direct sync; the pending reminder goes at once
    wr(8'h54, 16'h0203, 2'h0);
    pulse(1);
    chk("timer a transfers", n_sa, 2);
    rd(8'h64, 32'h0b33, 2'h0);
    wr(8'h58, 16'h0b0c, 2'h0);
    wr(8'h54, 16'h0004, 2'h0);
    pulse(2);
    cur = 6'h0c;
    rd(8'h64, 32'h0b0c, 2'h0);
    // timer b PWM alone through the pattern
    pwm_b <= 6'h2a;
    wr(8'h5c, 16'h3f80, 2'h0);
    outs_chk(6'h08);
    wr(8'h5c, 16'h003f, 2'h0);
    rd(8'h64, {25'h0000016, 1'b0, cur}, 2'h0);
    $display("test transfers finished");
    give_verdict();
  end
endmodule : testbench
